// ==== rtl/spc_regs.sv ====
/*
 * Control register bank for the serial PHY: soft reset, main PLL setup and
 * receiver lane zero setup, driven straight out to the analog controls.
 * Assumes a single-cycle register port master synchronous to clk.
 */
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module spc_regs (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             phy_soft_reset_n,
    output logic             external_pad_ref,
    output logic             pll_ref_halve_enable,
    output logic      [6:0]  pll_frequency_multiplier,
    output logic             main_pll_enable,
    output logic      [8:0]  spread_spectrum_ref_shift,
    output logic             lane0_receiver_reset,
    output logic      [1:0]  lane0_receive_rate,
    output logic             lane0_receive_rate_valid,
    output logic             lane0_receive_pll_enable,
    output logic             lane0_receive_data_enable,
    output logic             lane0_word_align_enable
);

    logic [15:0] soft_reset_reg;
    logic [15:0] pll_one_reg;
    logic [15:0] pll_two_reg;
    logic [15:0] rx_cfg_reg;
    logic [15:0] rdata_reg;

    wire sel_reset = (reg_addr == spc_pkg::IDX_PHY_SOFT_RESET);
    wire sel_one   = (reg_addr == spc_pkg::IDX_PLL_CONFIG_ONE);
    wire sel_two   = (reg_addr == spc_pkg::IDX_PLL_CONFIG_TWO);
    wire sel_rx    = (reg_addr == spc_pkg::IDX_RX_LANE0_CFG1);

    // Masked write data, reserved bits dropped
    wire [15:0] wr_reset = reg_wdata & spc_pkg::MSK_PHY_SOFT_RESET;
    wire [15:0] wr_one   = reg_wdata & spc_pkg::MSK_PLL_CONFIG_ONE;
    wire [15:0] wr_two   = reg_wdata & spc_pkg::MSK_PLL_CONFIG_TWO;
    wire [15:0] wr_rx    = reg_wdata & spc_pkg::MSK_RX_LANE0_CFG1;

    // Unmapped addresses read zero
    wire [15:0] rd_mux = sel_reset ? soft_reset_reg :
                         sel_one   ? pll_one_reg :
                         sel_two   ? pll_two_reg :
                         sel_rx    ? rx_cfg_reg : 16'h0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            soft_reset_reg <= spc_pkg::RST_PHY_SOFT_RESET;
            pll_one_reg    <= spc_pkg::RST_PLL_CONFIG_ONE;
            pll_two_reg    <= spc_pkg::RST_PLL_CONFIG_TWO;
            rx_cfg_reg     <= spc_pkg::RST_RX_LANE0_CFG1;
        end else if (reg_wr) begin
            if (sel_reset) begin
                soft_reset_reg <= wr_reset;
            end
            if (sel_one) begin
                pll_one_reg <= wr_one;
            end
            if (sel_two) begin
                pll_two_reg <= wr_two;
            end
            if (sel_rx) begin
                rx_cfg_reg <= wr_rx;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 16'h0000;
        end else if (reg_rd) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_reg;

    // Field decode onto the analog controls
    assign phy_soft_reset_n          = soft_reset_reg[spc_pkg::POS_SOFT_RESET_N];
    assign external_pad_ref          = pll_one_reg[spc_pkg::POS_REF_SELECT];
    assign pll_ref_halve_enable      = pll_one_reg[spc_pkg::POS_REF_HALVE];
    assign pll_frequency_multiplier  = pll_one_reg[spc_pkg::POS_MULT_LO +: spc_pkg::MULT_W];
    assign main_pll_enable           = pll_one_reg[spc_pkg::POS_PLL_EN];
    assign spread_spectrum_ref_shift = pll_two_reg[spc_pkg::POS_SSC_LO +: spc_pkg::SSC_W];
    assign lane0_receiver_reset      = rx_cfg_reg[spc_pkg::POS_RX_RESET];
    assign lane0_receive_rate        = rx_cfg_reg[spc_pkg::POS_RX_RATE_LO +: spc_pkg::RATE_W];
    // Flags the reserved rate code so the PHY wrapper can ignore it
    assign lane0_receive_rate_valid  = (lane0_receive_rate != spc_pkg::RATE_RSVD);
    assign lane0_receive_pll_enable  = rx_cfg_reg[spc_pkg::POS_RX_PLL_EN];
    assign lane0_receive_data_enable = rx_cfg_reg[spc_pkg::POS_RX_DATA_EN];
    assign lane0_word_align_enable   = rx_cfg_reg[spc_pkg::POS_RX_ALIGN_EN];

    property p_soft_reset_write;
        @(posedge clk) disable iff (rst)
        (reg_wr && sel_reset) |=> (phy_soft_reset_n == $past(reg_wdata[0]));
    endproperty
    a_soft_reset_write: assert property (p_soft_reset_write) else $error("soft reset bit not written");

    property p_ref_select;
        @(posedge clk) disable iff (rst)
        (reg_wr && sel_one) |=> (external_pad_ref == $past(reg_wdata[10]));
    endproperty
    a_ref_select: assert property (p_ref_select) else $error("reference select wrong");

    property p_ref_halve;
        @(posedge clk) disable iff (rst)
        (reg_wr && sel_one) |=> (pll_ref_halve_enable == $past(reg_wdata[8]));
    endproperty
    a_ref_halve: assert property (p_ref_halve) else $error("reference halve wrong");

    property p_multiplier;
        @(posedge clk) disable iff (rst)
        (reg_wr && sel_one) |=> (pll_frequency_multiplier == $past(reg_wdata[7:1]));
    endproperty
    a_multiplier: assert property (p_multiplier) else $error("multiplier wrong");

    property p_pll_reset;
        @(posedge clk) $rose(rst) ##0 rst |=> (!main_pll_enable && phy_soft_reset_n);
    endproperty
    a_pll_reset: assert property (p_pll_reset) else $error("reset values wrong");

    property p_ssc_hold;
        @(posedge clk) disable iff (rst)
        !(reg_wr && sel_two) |=> $stable(spread_spectrum_ref_shift);
    endproperty
    a_ssc_hold: assert property (p_ssc_hold) else $error("spread shift changed without write");

    property p_rx_fields;
        @(posedge clk) disable iff (rst)
        (reg_wr && sel_rx) |=> (lane0_receiver_reset == $past(reg_wdata[5]))
            && (lane0_receive_rate == $past(reg_wdata[4:3]))
            && (lane0_receive_pll_enable == $past(reg_wdata[2]));
    endproperty
    a_rx_fields: assert property (p_rx_fields) else $error("receiver fields wrong");

    property p_rx_enables;
        @(posedge clk) disable iff (rst)
        (reg_wr && sel_rx) |=> (lane0_receive_data_enable == $past(reg_wdata[1]))
            && (lane0_word_align_enable == $past(reg_wdata[0]));
    endproperty
    a_rx_enables: assert property (p_rx_enables) else $error("receiver enables wrong");

    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
        reg_rd ##1 1'b1 |-> ((reg_rdata & ~($past(sel_one)   ? 16'h05ff :
                                             $past(sel_reset) ? 16'h0001 :
                                             $past(sel_rx)    ? 16'h003f : 16'h01ff)) == 16'h0000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    // Fields hold between writes
    property p_soft_reset_hold;
        @(posedge clk) disable iff (rst)
        !(reg_wr && sel_reset) |=> $stable(phy_soft_reset_n);
    endproperty
    a_soft_reset_hold: assert property (p_soft_reset_hold) else $error("soft reset changed without write");

    property p_one_hold;
        @(posedge clk) disable iff (rst)
        !(reg_wr && sel_one) |=> $stable({external_pad_ref, pll_ref_halve_enable,
                                          pll_frequency_multiplier, main_pll_enable});
    endproperty
    a_one_hold: assert property (p_one_hold) else $error("pll config one changed without write");

    property p_rx_hold;
        @(posedge clk) disable iff (rst)
        !(reg_wr && sel_rx) |=> $stable({lane0_receiver_reset, lane0_receive_rate, lane0_receive_pll_enable,
                                         lane0_receive_data_enable, lane0_word_align_enable});
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receiver config changed without write");

    property p_pll_enable_write;
        @(posedge clk) disable iff (rst)
        (reg_wr && sel_one) |=> (main_pll_enable == $past(reg_wdata[0]));
    endproperty
    a_pll_enable_write: assert property (p_pll_enable_write) else $error("pll enable not written");

    property p_ssc_write;
        @(posedge clk) disable iff (rst)
        (reg_wr && sel_two) |=> (spread_spectrum_ref_shift == $past(reg_wdata[8:0]));
    endproperty
    a_ssc_write: assert property (p_ssc_write) else $error("spread shift not written");

    property p_rate_reserved;
        @(posedge clk) disable iff (rst)
        (lane0_receive_rate == 2'h3) |-> !lane0_receive_rate_valid;
    endproperty
    a_rate_reserved: assert property (p_rate_reserved) else $error("reserved rate flagged valid");

    property p_rate_legal;
        @(posedge clk) disable iff (rst)
        !lane0_receive_rate_valid |-> (lane0_receive_rate == 2'h3);
    endproperty
    a_rate_legal: assert property (p_rate_legal) else $error("legal rate flagged invalid");

    property p_rx_reset_values;
        @(posedge clk)
        $rose(rst) ##0 rst |=> (!lane0_word_align_enable && !lane0_receive_data_enable
            && !lane0_receive_pll_enable && !lane0_receiver_reset
            && (lane0_receive_rate == 2'h0));
    endproperty
    a_rx_reset_values: assert property (p_rx_reset_values) else $error("receiver reset values wrong");

    property p_ssc_reset_value;
        @(posedge clk)
        $rose(rst) ##0 rst |=> (spread_spectrum_ref_shift == 9'h000);
    endproperty
    a_ssc_reset_value: assert property (p_ssc_reset_value) else $error("spread shift reset value wrong");

    // Readback matches the fields driven out
    property p_soft_reset_read;
        @(posedge clk) disable iff (rst)
        (reg_rd && sel_reset) |=> (reg_rdata == {15'h0000, $past(phy_soft_reset_n)});
    endproperty
    a_soft_reset_read: assert property (p_soft_reset_read) else $error("soft reset readback wrong");

    property p_ref_read;
        @(posedge clk) disable iff (rst)
        (reg_rd && sel_one) |=> (reg_rdata[10] == $past(external_pad_ref))
            && (reg_rdata[8] == $past(pll_ref_halve_enable));
    endproperty
    a_ref_read: assert property (p_ref_read) else $error("reference bits readback wrong");

    property p_mult_read;
        @(posedge clk) disable iff (rst)
        (reg_rd && sel_one) |=> (reg_rdata[7:1] == $past(pll_frequency_multiplier))
            && (reg_rdata[0] == $past(main_pll_enable));
    endproperty
    a_mult_read: assert property (p_mult_read) else $error("multiplier readback wrong");

    property p_ssc_read;
        @(posedge clk) disable iff (rst)
        (reg_rd && sel_two) |=> (reg_rdata[8:0] == $past(spread_spectrum_ref_shift));
    endproperty
    a_ssc_read: assert property (p_ssc_read) else $error("spread shift readback wrong");

    property p_rx_reset_read;
        @(posedge clk) disable iff (rst)
        (reg_rd && sel_rx) |=> (reg_rdata[5:3] == $past({lane0_receiver_reset, lane0_receive_rate}));
    endproperty
    a_rx_reset_read: assert property (p_rx_reset_read) else $error("receiver reset readback wrong");

    property p_rx_pll_read;
        @(posedge clk) disable iff (rst)
        (reg_rd && sel_rx) |=> (reg_rdata[2] == $past(lane0_receive_pll_enable));
    endproperty
    a_rx_pll_read: assert property (p_rx_pll_read) else $error("receive pll readback wrong");

    property p_rx_data_read;
        @(posedge clk) disable iff (rst)
        (reg_rd && sel_rx) |=> (reg_rdata[1] == $past(lane0_receive_data_enable));
    endproperty
    a_rx_data_read: assert property (p_rx_data_read) else $error("receive data readback wrong");

    property p_align_read;
        @(posedge clk) disable iff (rst)
        (reg_rd && sel_rx) |=> (reg_rdata[0] == $past(lane0_word_align_enable));
    endproperty
    a_align_read: assert property (p_align_read) else $error("word align readback wrong");

    // Read port quiet and reserved space empty
    property p_idle_read;
        @(posedge clk) disable iff (rst)
        !reg_rd |=> (reg_rdata == 16'h0000);
    endproperty
    a_idle_read: assert property (p_idle_read) else $error("read data not zero when idle");

    property p_unmapped_read;
        @(posedge clk) disable iff (rst)
        (reg_rd && !(sel_reset || sel_one || sel_two || sel_rx)) |=> (reg_rdata == 16'h0000);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero");

    property p_one_reserved;
        @(posedge clk) disable iff (rst)
        (reg_rd && sel_one) |=> (reg_rdata[15:11] == 5'h00)
            && (reg_rdata[9] == 1'b0);
    endproperty
    a_one_reserved: assert property (p_one_reserved) else $error("pll config one reserved nonzero");

    property p_two_reserved;
        @(posedge clk) disable iff (rst)
        (reg_rd && sel_two) |=> (reg_rdata[15:9] == 7'h00);
    endproperty
    a_two_reserved: assert property (p_two_reserved) else $error("pll config two reserved nonzero");

    property p_rx_reserved;
        @(posedge clk) disable iff (rst)
        (reg_rd && sel_rx) |=> (reg_rdata[15:6] == 10'h000);
    endproperty
    a_rx_reserved: assert property (p_rx_reserved) else $error("receiver config reserved nonzero");

endmodule

// ==== inc/spc_pkg.sv ====
/*
 * Package for the PHY control register bank: register indices, field
 * positions, widths and reset values.
 * Assumes the register port carries 16-bit data words at word indices.
 */
package spc_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;

    // Register indices on the plain register port
    localparam logic [15:0] IDX_PHY_SOFT_RESET = 16'hd000;
    localparam logic [15:0] IDX_PLL_CONFIG_ONE = 16'hd001;
    localparam logic [15:0] IDX_PLL_CONFIG_TWO = 16'hd002;
    localparam logic [15:0] IDX_RX_LANE0_CFG1  = 16'hd003;

    // Reset values
    localparam logic [15:0] RST_PHY_SOFT_RESET = 16'h0001;
    localparam logic [15:0] RST_PLL_CONFIG_ONE = 16'h0000;
    localparam logic [15:0] RST_PLL_CONFIG_TWO = 16'h0000;
    localparam logic [15:0] RST_RX_LANE0_CFG1  = 16'h0000;

    // Writable bit masks; all other bits are reserved
    localparam logic [15:0] MSK_PHY_SOFT_RESET = 16'h0001;
    localparam logic [15:0] MSK_PLL_CONFIG_ONE = 16'h05ff;
    localparam logic [15:0] MSK_PLL_CONFIG_TWO = 16'h01ff;
    localparam logic [15:0] MSK_RX_LANE0_CFG1  = 16'h003f;

    // Field positions
    localparam int unsigned POS_SOFT_RESET_N   = 0;
    localparam int unsigned POS_REF_SELECT     = 10;
    localparam int unsigned POS_REF_HALVE      = 8;
    localparam int unsigned POS_MULT_LO        = 1;
    localparam int unsigned MULT_W             = 7;
    localparam int unsigned POS_PLL_EN         = 0;
    localparam int unsigned POS_SSC_LO         = 0;
    localparam int unsigned SSC_W              = 9;
    localparam int unsigned POS_RX_RESET       = 5;
    localparam int unsigned POS_RX_RATE_LO     = 3;
    localparam int unsigned RATE_W             = 2;
    localparam int unsigned POS_RX_PLL_EN      = 2;
    localparam int unsigned POS_RX_DATA_EN     = 1;
    localparam int unsigned POS_RX_ALIGN_EN    = 0;

    // Receive rate encodings
    localparam logic [1:0] RATE_DIV1 = 2'h0;
    localparam logic [1:0] RATE_DIV2 = 2'h1;
    localparam logic [1:0] RATE_DIV4 = 2'h2;
    localparam logic [1:0] RATE_RSVD = 2'h3;

endpackage

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench for the PHY control register bank: register reads and
 * writes on the plain port, compared against a register model and the outputs.
 * Assumes one 40 MHz clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module tb_top;
    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic [15:0] reg_addr  = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [15:0] reg_rdata;
    logic        soft_n, pad_ref, halve, pll_en, rx_rst, rate_ok, rx_pll, rx_data, align;
    logic [6:0]  mult;
    logic [8:0]  ssc;
    logic [1:0]  rate;
    logic [15:0] mdl     [4];
    logic [15:0] addr_of [4] = '{spc_pkg::IDX_PHY_SOFT_RESET, spc_pkg::IDX_PLL_CONFIG_ONE,
                                 spc_pkg::IDX_PLL_CONFIG_TWO, spc_pkg::IDX_RX_LANE0_CFG1};
    logic [15:0] msk_of  [4] = '{16'h0001, 16'h05ff, 16'h01ff, 16'h003f};
    int          failures        = 0;
    int          samples_checked = 0;

    spc_regs dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phy_soft_reset_n(soft_n), .external_pad_ref(pad_ref),
        .pll_ref_halve_enable(halve), .pll_frequency_multiplier(mult), .main_pll_enable(pll_en),
        .spread_spectrum_ref_shift(ssc), .lane0_receiver_reset(rx_rst), .lane0_receive_rate(rate),
        .lane0_receive_rate_valid(rate_ok), .lane0_receive_pll_enable(rx_pll),
        .lane0_receive_data_enable(rx_data), .lane0_word_align_enable(align));

    initial forever #12.5 clk = ~clk;

    task automatic conclude();
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Outputs against the model, packed in port order
    task automatic cmp_out();
        logic [26:0] e, s;
        e = {mdl[0][0], mdl[1][10], mdl[1][8], mdl[1][7:1], mdl[1][0], mdl[2][8:0], mdl[3][5],
             mdl[3][4:3], mdl[3][4:3] != 2'h3, mdl[3][2], mdl[3][1], mdl[3][0]};
        s = {soft_n, pad_ref, halve, mult, pll_en, ssc, rx_rst, rate, rate_ok, rx_pll, rx_data, align};
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("[ERR] outputs expected %h seen %h", e, s);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        for (int k = 0; k < 4; k++) if (addr_of[k] == a) mdl[k] = d & msk_of[k];
        #1 cmp_out();
    endtask

    task automatic rd(input logic [15:0] a);
        logic [15:0] e;
        e = 16'h0000;
        for (int k = 0; k < 4; k++) if (addr_of[k] == a) e = mdl[k];
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 cmp16("reg_rdata", e, reg_rdata);
        @(posedge clk);
        #1 cmp16("reg_rdata idle", 16'h0000, reg_rdata);
    endtask

    task automatic do_reset(input int n);
        @(posedge clk);
        rst <= 1'b1;
        repeat (n) @(posedge clk);
        rst <= 1'b0;
        mdl = '{16'h0001, 16'h0000, 16'h0000, 16'h0000};
        #1 cmp_out();
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        conclude();
    end

    initial begin
        do_reset(10);
        for (int k = 0; k < 4; k++) rd(addr_of[k]);
        for (int k = 0; k < 4; k++) wr(addr_of[k], 16'hffff);
        for (int k = 0; k < 4; k++) rd(addr_of[k]);
        for (int k = 0; k < 4; k++) wr(addr_of[k], 16'h0000);
        for (int b = 0; b < 16; b++) begin
            wr(spc_pkg::IDX_PLL_CONFIG_ONE, 16'h0001 << b);
            rd(spc_pkg::IDX_PLL_CONFIG_ONE);
            wr(spc_pkg::IDX_PLL_CONFIG_TWO, 16'h0001 << b);
            wr(spc_pkg::IDX_RX_LANE0_CFG1, 16'h0001 << b);
            rd(spc_pkg::IDX_RX_LANE0_CFG1);
        end
        for (int r = 0; r < 4; r++) wr(spc_pkg::IDX_RX_LANE0_CFG1, 16'(r << 3));
        wr(spc_pkg::IDX_PHY_SOFT_RESET, 16'hfffe);
        rd(spc_pkg::IDX_PHY_SOFT_RESET);
        wr(spc_pkg::IDX_PHY_SOFT_RESET, 16'h0001);
        wr(16'hd004, 16'hffff);
        rd(16'hd004);
        for (int k = 0; k < 4; k++) rd(addr_of[k]);
        // Write then read with no gap
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= spc_pkg::IDX_PLL_CONFIG_TWO;
        reg_wdata <= 16'hfe55;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        mdl[2] = 16'h0055;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 cmp16("reg_rdata b2b", 16'h0055, reg_rdata);
        cmp_out();
        wr(spc_pkg::IDX_PLL_CONFIG_ONE, 16'h0403);
        wr(spc_pkg::IDX_PHY_SOFT_RESET, 16'h0000);
        do_reset(2);
        for (int k = 0; k < 4; k++) rd(addr_of[k]);
        conclude();
    end
endmodule
